// file: design/cets_pkg.sv
// ============================================================================
// Purpose: Shared constants and types for the camera exposure trigger sequencer
// Assumes: 100 MHz system clock, Avalon-MM register slave with 32-bit data
// Notes:   Exposure and frame interval are programmed in system clock cycles
// ============================================================================
package cets_pkg;

    // ========================================================================
    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int BE_W = 4;
    localparam int CLK_MHZ = 100;

    // ========================================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] EXPOSURE_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] INTERVAL_OFS = 5'h08;
    localparam logic [ADDR_W-1:0] FRAMES_OFS = 5'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h10;

    // ========================================================================
    // Control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CAPTURE_BIT = 1;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_POL_BIT = 4;

    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_IGNORED_BIT = 4;
    localparam int STAT_FRAMES_LSB = 16;
    localparam int STAT_FRAMES_W = 16;

    // ========================================================================
    // external_start_source_select codes
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_STANDARD = 2'h1;
    localparam logic [1:0] SRC_PULSE_WIDTH = 2'h2;

    // ========================================================================
    // Reset values
    localparam logic [DATA_W-1:0] EXPOSURE_RST = 32'h0000_0064;
    localparam logic [DATA_W-1:0] INTERVAL_RST = 32'h0000_03E8;
    localparam logic [DATA_W-1:0] FRAMES_RST = 32'h0000_0001;
    localparam logic [DATA_W-1:0] ONE_W = 32'h0000_0001;
    localparam logic START_POL_RST = 1'b0;

    // ========================================================================
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_EXPOSE = 4'h2,
        S_READOUT = 4'h4,
        S_WAIT = 4'h8
    } cets_state_t;

endpackage

// file: design/cets_sequencer.sv
// ============================================================================
// Purpose: Exposure sequencer with external trigger, Avalon-MM register slave
// Assumes: Readout logic runs on clk_i and answers with busy and done
// Notes:   Times are programmed as clk_i cycles; all outputs are registered
// ============================================================================
// How it works
// - Three trigger modes exist: streaming, asynchronous single frame, and bulb.
// - Readout rate, binning, gain and offset never change trigger handling.
// - Reference trigger is active low: falling edge starts, idle level high.
// - Streaming: trigger starts exposure of programmed length, then readout.
// - Streaming: exposure plus readout repeats at frame interval without triggers.
// - Streaming: later triggers ignored until host halts acquisition or a nonzero frame count is reached.
// - Asynchronous: each trigger gives one timed exposure and one readout.
// - Asynchronous: triggers during readout are dropped, never queued.
// - Asynchronous: after readout stay idle until a new trigger.
// - Bulb: exposure runs from trigger assert to deassert, then readout.
// - Bulb: trigger transitions during readout are ignored.
// - Source off: software capture acquires programmed frame count without trigger.
// - Polarity bit picks rising or falling edge as exposure start.
// - Strobe output is high for the whole of every exposure.
`timescale 1ns/10ps
module cets_sequencer
    import cets_pkg::*;
(
    input wire logic clk_i, // System clock, 100 MHz
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic trig_pin_i, // External trigger pin
    input wire logic readout_busy_i, // Readout logic is busy
    input wire logic readout_done_i, // Readout finished, one-cycle pulse
    input wire logic [ADDR_W-1:0] avs_address_i, // Register byte address
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [DATA_W-1:0] avs_writedata_i, // Write data
    input wire logic [BE_W-1:0] avs_byteenable_i, // Write byte lanes
    output logic [DATA_W-1:0] avs_readdata_o, // Read data
    output logic avs_waitrequest_o, // Slave not ready
    output logic strobe_o, // High during exposure
    output logic readout_start_o, // One-cycle readout request
    output logic acq_active_o // Sequencer not idle
);

    // ========================================================================
    // State record
    typedef struct packed {
        cets_state_t st;
        logic [DATA_W-1:0] cnt;
        logic [DATA_W-1:0] ivl;
        logic [DATA_W-1:0] done;
        logic en;
        logic cap;
        logic [1:0] src;
        logic pol;
        logic [DATA_W-1:0] expo;
        logic [DATA_W-1:0] per;
        logic [DATA_W-1:0] nfr;
        logic wr;
        logic [DATA_W-1:0] rd;
        logic ro;
        logic stb;
        logic ign;
        logic act;
    } cets_seq_t;

    cets_seq_t q, d;

    logic trig_on;
    logic trig_off;
    logic [DATA_W-1:0] be_mask;
    logic stream_mode;
    logic async_mode;
    logic bulb_mode;
    logic soft_mode;
    logic trig_mode;
    logic last_frame;

    // ========================================================================
    // Trigger synchroniser and edge detect
    cets_trig_sync u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .trig_pin_i(trig_pin_i),
        .start_edge_polarity_i(q.pol),
        .assert_o(trig_on),
        .deassert_o(trig_off)
    );

    // ========================================================================
    // Byte lane mask for register writes
    for (genvar gi = 0; gi < BE_W; gi++) begin : g_lane
        assign be_mask[8*gi +: 8] = {8{avs_byteenable_i[gi]}};
    end

    // Merge write data into an old register value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old);
        return (old & ~be_mask) | (avs_writedata_i & be_mask);
    endfunction

    // ========================================================================
    // Mode decode; readout speed and gain have no input here
    assign stream_mode = (q.src == SRC_STANDARD) && (q.nfr != ONE_W);
    assign async_mode = (q.src == SRC_STANDARD) && (q.nfr == ONE_W);
    assign bulb_mode = (q.src == SRC_PULSE_WIDTH);
    assign soft_mode = (q.src == SRC_NONE);
    assign trig_mode = stream_mode | async_mode | bulb_mode;

    // Frame quota reached after this readout; zero count runs forever
    assign last_frame = (q.nfr != '0) && ((q.done + ONE_W) >= q.nfr);

    // ========================================================================
    // Next-state logic: bus slave and sequencer
    always_comb begin
        d = q;
        d.cap = 1'b0;
        d.ro = 1'b0;
        d.wr = 1'b1;

        // Accept a request one cycle after it shows, read data ready then
        if ((avs_read_i || avs_write_i) && q.wr) begin
            d.wr = 1'b0;
            d.rd = '0;
            case (avs_address_i)
                CTRL_OFS: begin
                    d.rd[CTRL_ENABLE_BIT] = q.en;
                    d.rd[CTRL_SRC_LSB +: $bits(q.src)] = q.src;
                    d.rd[CTRL_POL_BIT] = q.pol;
                end
                EXPOSURE_OFS: d.rd = q.expo;
                INTERVAL_OFS: d.rd = q.per;
                FRAMES_OFS: d.rd = q.nfr;
                STATUS_OFS: begin
                    d.rd[STAT_STATE_LSB +: $bits(cets_state_t)] = q.st;
                    d.rd[STAT_IGNORED_BIT] = q.ign;
                    d.rd[STAT_FRAMES_LSB +: STAT_FRAMES_W] = q.done[STAT_FRAMES_W-1:0];
                end
                default: d.rd = '0;
            endcase
        end

        // Writes land on the edge where waitrequest is low
        if (avs_write_i && !q.wr) begin
            case (avs_address_i)
                CTRL_OFS: begin
                    if (avs_byteenable_i[0]) begin
                        d.en = avs_writedata_i[CTRL_ENABLE_BIT];
                        d.cap = avs_writedata_i[CTRL_CAPTURE_BIT];
                        d.src = avs_writedata_i[CTRL_SRC_LSB +: $bits(d.src)];
                        d.pol = avs_writedata_i[CTRL_POL_BIT];
                    end
                end
                EXPOSURE_OFS: d.expo = merge(q.expo);
                INTERVAL_OFS: d.per = merge(q.per);
                FRAMES_OFS: d.nfr = merge(q.nfr);
                STATUS_OFS: begin
                    if (avs_byteenable_i[0] && avs_writedata_i[STAT_IGNORED_BIT]) begin
                        d.ign = 1'b0;
                    end
                end
                default: d.ign = d.ign;
            endcase
        end

        // Interval counter measures time since the last exposure start
        if (q.ivl != '1) begin
            d.ivl = q.ivl + ONE_W;
        end

        // Any start edge outside idle is dropped; set wins over clear
        if (trig_on && trig_mode && (q.st != S_IDLE)) begin
            d.ign = 1'b1;
        end

        unique case (q.st)
            S_IDLE: begin
                // Start on trigger edge, or software capture with source off
                if (q.en && ((soft_mode && q.cap) ||
                             (trig_mode && trig_on && !readout_busy_i))) begin
                    d.st = S_EXPOSE;
                    d.cnt = ONE_W;
                    d.ivl = ONE_W;
                    d.done = '0;
                end else if (trig_on && trig_mode) begin
                    d.ign = 1'b1;
                end
            end
            S_EXPOSE: begin
                if (bulb_mode) begin
                    // Exposure length equals trigger pulse width
                    if (trig_off) begin
                        d.st = S_READOUT;
                        d.ro = 1'b1;
                    end
                end else if (q.cnt >= q.expo) begin
                    // Programmed exposure elapsed, request readout
                    d.st = S_READOUT;
                    d.ro = 1'b1;
                end else begin
                    d.cnt = q.cnt + ONE_W;
                end
            end
            S_READOUT: begin
                // Leave only on readout done
                if (readout_done_i) begin
                    d.done = q.done + ONE_W;
                    if ((stream_mode || soft_mode) && q.en && !last_frame) begin
                        d.st = S_WAIT;
                    end else begin
                        d.st = S_IDLE;
                    end
                end
            end
            S_WAIT: begin
                // Repeat at the frame interval; halt returns to idle
                if (!q.en) begin
                    d.st = S_IDLE;
                end else if (q.ivl >= q.per) begin
                    d.st = S_EXPOSE;
                    d.cnt = ONE_W;
                    d.ivl = ONE_W;
                end
            end
        endcase

        // Strobe follows the exposure state exactly
        d.stb = (d.st == S_EXPOSE);
        d.act = (d.st != S_IDLE); // Registered so the port comes from a flop
    end

    // ========================================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '{st: S_IDLE, cnt: '0, ivl: '0, done: '0, en: 1'b0, cap: 1'b0,
                   src: SRC_NONE, pol: START_POL_RST, expo: EXPOSURE_RST,
                   per: INTERVAL_RST, nfr: FRAMES_RST, wr: 1'b1, rd: '0,
                   ro: 1'b0, stb: 1'b0, ign: 1'b0, act: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs straight from flops
    assign avs_readdata_o = q.rd;
    assign avs_waitrequest_o = q.wr;
    assign strobe_o = q.stb;
    assign readout_start_o = q.ro;
    assign acq_active_o = q.act;

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Strobe high exactly while exposing
    a_strobe_tracks_exposure: assert property (
        strobe_o == (q.st == S_EXPOSE)
    ) else $error("strobe does not match exposure state");

    // End of exposure requests readout at once
    a_readout_after_exposure: assert property (
        $fell(strobe_o) |-> readout_start_o && (q.st == S_READOUT)
    ) else $error("exposure ended without readout request");

    // Timed exposure of four cycles lasts four cycles
    a_exposure_four_cycles: assert property (
        ($rose(strobe_o) && !bulb_mode && (q.expo == 32'h0000_0004) && $stable(q.src))
        |-> strobe_o[*4] ##1 !strobe_o
    ) else $error("exposure length differs from programmed count");

    // Asynchronous readout never chains into another exposure
    a_async_back_idle: assert property (
        (q.st == S_READOUT) && async_mode && readout_done_i |=> (q.st == S_IDLE)
    ) else $error("asynchronous mode did not return to idle");

    // Bulb exposure ends on the stop edge
    a_bulb_stop_edge: assert property (
        (q.st == S_EXPOSE) && bulb_mode && trig_off |=> (q.st == S_READOUT) && readout_start_o
    ) else $error("bulb exposure did not end on trigger release");

    // Trigger during readout leaves readout untouched
    a_readout_ignores_trig: assert property (
        (q.st == S_READOUT) && !readout_done_i && trig_on && trig_mode
        |=> (q.st == S_READOUT) && q.ign
    ) else $error("trigger disturbed readout");

    // Streaming wait repeats once the interval has run
    a_stream_repeat: assert property (
        (q.st == S_WAIT) && q.en && (q.ivl >= q.per) |=> strobe_o ##1 (q.ivl == 32'h0000_0002)
    ) else $error("frame interval did not restart exposure");

    // Halt ends a waiting sequence
    a_halt_to_idle: assert property (
        (q.st == S_WAIT) && !q.en |=> (q.st == S_IDLE) && !acq_active_o
    ) else $error("halt did not stop acquisition");

    // Bus answers one cycle after a request and then releases
    a_bus_one_wait: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o
    ) else $error("bus wait timing broken");

    // Timed exposure keeps running until the count is reached
    a_expose_holds_count: assert property (
        (q.st == S_EXPOSE) && !bulb_mode && (q.cnt < q.expo) |=> (q.st == S_EXPOSE) && strobe_o
    ) else $error("timed exposure ended early");

    // Bulb exposure stays open until the stop edge
    a_bulb_holds_open: assert property (
        (q.st == S_EXPOSE) && bulb_mode && !trig_off |=> (q.st == S_EXPOSE) && strobe_o
    ) else $error("bulb exposure ended without stop edge");

    // Accepted start edge opens an exposure next cycle
    a_trig_starts_exposure: assert property (
        (q.st == S_IDLE) && q.en && trig_mode && trig_on && !readout_busy_i
        |=> (q.st == S_EXPOSE) && strobe_o && (q.cnt == ONE_W)
    ) else $error("start edge did not open an exposure");

    // Software capture starts without the trigger pin
    a_soft_capture_start: assert property (
        (q.st == S_IDLE) && q.en && soft_mode && q.cap |=> (q.st == S_EXPOSE) && strobe_o
    ) else $error("software capture did not start");

    // Asynchronous idle waits for a fresh start edge
    a_async_stays_idle: assert property (
        (q.st == S_IDLE) && async_mode && !trig_on |=> (q.st == S_IDLE) && !acq_active_o
    ) else $error("asynchronous mode left idle without trigger");

    // Start edge outside idle is recorded as ignored
    a_ignore_sets_flag: assert property (
        trig_on && trig_mode && (q.st != S_IDLE) |=> q.ign
    ) else $error("ignored trigger not recorded");

    // Readout request is a single-cycle pulse
    a_readout_single_pulse: assert property (
        readout_start_o |=> !readout_start_o
    ) else $error("readout request longer than one cycle");

    // Each readout done adds one frame to the count
    a_frames_counted: assert property (
        (q.st == S_READOUT) && readout_done_i |=> (q.done == $past(q.done) + ONE_W)
    ) else $error("frame count not advanced");

endmodule // cets_sequencer

// file: design/cets_trig_sync.sv
// ============================================================================
// Purpose: Trigger pin synchroniser and start/stop edge detector
// Assumes: Trigger pin is asynchronous to clk_i
// Notes:   Polarity 0 starts on the falling edge, 1 on the rising edge
// ============================================================================
`timescale 1ns/10ps
module cets_trig_sync
    import cets_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic trig_pin_i, // Raw trigger pin
    input wire logic start_edge_polarity_i, // 1 rising starts, 0 falling starts
    output logic assert_o, // One-cycle pulse on the start edge
    output logic deassert_o // One-cycle pulse on the stop edge
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } cets_sync_t;

    cets_sync_t q, d;

    // Two stages before any logic, third stage holds the old level
    always_comb begin
        d = q;
        d.meta = trig_pin_i;
        d.sync = q.meta;
        d.last = q.sync;
    end

    // Idle line is high, so the stages reset high
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
        end else begin
            q <= d;
        end
    end

    // Edge decode after the synchroniser
    assign assert_o = start_edge_polarity_i ? (q.sync & ~q.last) : (~q.sync & q.last);
    assign deassert_o = start_edge_polarity_i ? (~q.sync & q.last) : (q.sync & ~q.last);

endmodule // cets_trig_sync

// file: sim/cets_trig_host.sv
// Purpose: Model of the external controller that drives the trigger pin
// Assumes: Pulses are requested by the bench one at a time
// Notes:   Idle level is the inverse of the start level
`timescale 1ns/10ps
module cets_trig_host (
    input wire logic clk_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic fire_i, // Start one pulse
    input wire logic [15:0] width_i, // Pulse width in cycles
    input wire logic start_rising_i, // 1 pulses high, 0 pulses low
    output logic trig_pin_o // Trigger pin
);
    logic [15:0] left_q;

    // Count down the active part of the pulse
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            left_q <= 16'h0000;
        end else if (fire_i && left_q == 16'h0000) begin
            left_q <= width_i;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
        end
    end

    // Active low by default: idle high, asserted low
    assign trig_pin_o = (left_q != 16'h0000) ? start_rising_i : !start_rising_i;
endmodule // cets_trig_host

// file: sim/testbench.sv
// Purpose: Self-checking bench for the exposure sequencer
// Assumes: Readout logic modelled here with a fixed busy time
// Notes:   Exposure 4 cycles, interval 60 cycles, readout 30 cycles
`timescale 1ns/10ps
module testbench
    import cets_pkg::*;
;
    localparam logic [31:0] EN = 32'h0000_0001;
    localparam logic [31:0] CAP = 32'h0000_0002;
    localparam logic [31:0] SRC1 = 32'h0000_0004;
    localparam logic [31:0] SRC2 = 32'h0000_0008;
    localparam logic [31:0] POL = 32'h0000_0010;
    logic clk_i, resetn_i, fire, rising, rd, wr, strobe, rstart, act, waitreq;
    logic rbusy = 1'b0;
    logic rdone = 1'b0;
    logic pin;
    logic [15:0] width;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [BE_W-1:0] be;
    int rcnt, n_exp, n_rd, run, last_len, cyc, rise_at, gap, b, err_count, num_checks;

    cets_trig_host cets_trig_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .fire_i(fire),
        .width_i(width), .start_rising_i(rising), .trig_pin_o(pin));
    cets_sequencer cets_sequencer_inst (.clk_i(clk_i), .resetn_i(resetn_i), .trig_pin_i(pin),
        .readout_busy_i(rbusy), .readout_done_i(rdone), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .strobe_o(strobe), .readout_start_o(rstart), .acq_active_o(act));

    // =====================================================================
    // Readout logic model: busy for 30 cycles, then a done pulse
    always @(posedge clk_i) begin
        rdone <= 1'b0;
        if (!resetn_i) begin
            rbusy <= 1'b0;
        end else if (rstart === 1'b1) begin
            rbusy <= 1'b1;
            rcnt <= 30;
        end else if (rbusy) begin
            if (rcnt <= 1) begin
                rdone <= 1'b1;
                rbusy <= 1'b0;
            end
            rcnt <= rcnt - 1;
        end
    end

    // Measure exposures, their length and start-to-start spacing
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (!resetn_i) begin
            n_exp <= 0; n_rd <= 0; run <= 0; last_len <= 0; gap <= 0; rise_at <= 0;
        end else begin
            if (strobe === 1'b1) run <= run + 1;
            else if (run != 0) begin last_len <= run; run <= 0; end
            if (strobe === 1'b1 && run == 0) begin
                n_exp <= n_exp + 1; gap <= cyc - rise_at; rise_at <= cyc;
            end
            if (rstart === 1'b1) n_rd <= n_rd + 1;
        end
    end

    // =====================================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a; wdata <= d; wr <= w; rd <= !w;
        do begin
            @(posedge clk_i);
        end while (waitreq !== 1'b0);
        v = rdata;
        wr <= 1'b0; rd <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(v, exp);
    endtask

    task automatic fire_pulse(input int w);
        @(posedge clk_i);
        fire <= 1'b1; width <= 16'(w);
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (6) @(posedge clk_i);
        while ((act !== 1'b0 || rbusy) && n < 3000) begin @(posedge clk_i); n++; end
        if (n >= 3000) begin
            chk(32'h0000_0001, 32'h0000_0000);
            tally_and_finish();
        end
    endtask

    task automatic wait_readout(input int base);
        while (n_rd == base) @(posedge clk_i);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // =====================================================================
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Watchdog
    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end

    // Tests
    initial begin
        resetn_i = 1'b0; fire = 1'b0; width = 16'h0000; rising = 1'b0; rd = 1'b0;
        wr = 1'b0; addr = '0; wdata = '0; be = 4'hF; err_count = 0; num_checks = 0;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdchk(CTRL_OFS, 32'h0000_0000);
        rdchk(EXPOSURE_OFS, EXPOSURE_RST);
        rdchk(INTERVAL_OFS, INTERVAL_RST);
        rdchk(FRAMES_OFS, FRAMES_RST);
        rdchk(STATUS_OFS, 32'h0000_0001);
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        rdchk(5'h14, 32'h0000_0000);
        $display("test reset values done");
        // Asynchronous: one frame per trigger, readout-time triggers dropped
        bus(1'b1, EXPOSURE_OFS, 32'h0000_0004);
        bus(1'b1, INTERVAL_OFS, 32'h0000_003C);
        bus(1'b1, CTRL_OFS, EN | SRC1);
        b = n_exp;
        fire_pulse(5);
        wait_readout(n_rd);
        fire_pulse(5);
        wait_idle();
        chk(n_exp - b, 1);
        chk(last_len, 4);
        rdchk(STATUS_OFS, 32'h0001_0011);
        bus(1'b1, STATUS_OFS, 32'h0000_0010);
        rdchk(STATUS_OFS, 32'h0001_0001);
        repeat (40) @(posedge clk_i);
        chk(n_exp - b, 1);
        fire_pulse(5);
        wait_idle();
        chk(n_exp - b, 2);
        $display("test asynchronous done");
        // Streaming: three frames from one trigger, extra trigger ignored
        bus(1'b1, FRAMES_OFS, 32'h0000_0003);
        b = n_exp;
        fire_pulse(5);
        wait_readout(n_rd);
        fire_pulse(5);
        wait_idle();
        chk(n_exp - b, 3);
        chk(gap, 60);
        rdchk(STATUS_OFS, 32'h0003_0011);
        // Endless streaming until halted
        bus(1'b1, FRAMES_OFS, 32'h0000_0000);
        b = n_exp;
        fire_pulse(5);
        repeat (228) @(posedge clk_i); // Halt lands in the wait after frame four
        bus(1'b1, CTRL_OFS, 32'h0000_0000);
        wait_idle();
        chk(n_exp - b, 4);
        $display("test streaming done");
        // Bulb: exposure follows pulse width, readout-time edges ignored
        bus(1'b1, CTRL_OFS, EN | SRC2);
        b = n_exp;
        fire_pulse(12);
        wait_readout(n_rd);
        fire_pulse(3);
        wait_idle();
        chk(n_exp - b, 1);
        chk(last_len, 12);
        $display("test bulb done");
        // Rising-edge polarity in asynchronous mode
        bus(1'b1, FRAMES_OFS, 32'h0000_0001);
        bus(1'b1, CTRL_OFS, SRC1 | POL);
        rising <= 1'b1;
        repeat (5) @(posedge clk_i);
        bus(1'b1, CTRL_OFS, EN | SRC1 | POL);
        b = n_exp;
        fire_pulse(5);
        wait_idle();
        chk(n_exp - b, 1);
        chk(last_len, 4);
        bus(1'b1, CTRL_OFS, 32'h0000_0000);
        rising <= 1'b0;
        $display("test polarity done");
        // Software capture without trigger source
        bus(1'b1, FRAMES_OFS, 32'h0000_0002);
        b = n_exp;
        bus(1'b1, CTRL_OFS, EN | CAP);
        wait_idle();
        chk(n_exp - b, 2);
        chk(last_len, 4);
        rdchk(CTRL_OFS, EN);
        $display("test software capture done");
        tally_and_finish();
    end
endmodule // testbench
